// ---- core/iref_flag.sv ----
// Purpose : One sticky status flag, set wins over clear
// Assumes : Set and clear are single clock pulses on clk_i
// Notes   : Instantiated once per error bit
`default_nettype none

module iref_flag (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic set_i,
   input  wire logic clr_i,
   output logic      flag_o
);

   typedef struct packed {
      logic flag;
   } iref_flag_state_t;

   iref_flag_state_t s_q;
   iref_flag_state_t s_d;

   // Set has priority so a coincident event is never lost
   always_comb begin
      s_d = s_q;
      if (set_i) begin
         s_d.flag = 1'b1;
      end else if (clr_i) begin
         s_d.flag = 1'b0;
      end
   end

   // Synchronous reset to zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign flag_o = s_q.flag;

endmodule : iref_flag

`default_nettype wire

// ---- core/iref_pkg.sv ----
// Purpose : Shared constants for the interrupt enable and error flag block
// Assumes : 32-bit classic Wishbone, word aligned registers
// Notes   : Register indices are multiplied by four for the byte address
`default_nettype none

package iref_pkg;

   // ****************************************************************
   // Register indices and byte addresses
   // ****************************************************************
   localparam logic [7:0] IREF_IDX_ENABLE_TWO = 8'h09;
   localparam logic [7:0] IREF_IDX_ERROR      = 8'h0A;
   localparam logic [7:0] IREF_IDX_CONTROL    = 8'h0C;
   localparam logic [7:0] IREF_IDX_COLL_POS   = 8'h0D;
   localparam int         IREF_ADDR_W         = 8;
   localparam logic [7:0] IREF_ADDR_ENABLE_TWO = 8'(IREF_IDX_ENABLE_TWO * 4);
   localparam logic [7:0] IREF_ADDR_ERROR      = 8'(IREF_IDX_ERROR * 4);
   localparam logic [7:0] IREF_ADDR_CONTROL    = 8'(IREF_IDX_CONTROL * 4);
   localparam logic [7:0] IREF_ADDR_COLL_POS   = 8'(IREF_IDX_COLL_POS * 4);

   // ****************************************************************
   // Enable register fields
   // ****************************************************************
   localparam int IREF_EN_PIN_DRIVE   = 7;
   localparam int IREF_EN_PIN_GATE    = 6;
   localparam int IREF_EN_CARD_DETECT = 5;
   localparam int IREF_EN_TIMER_HI    = 4;
   localparam int IREF_EN_TIMER_LO    = 0;
   localparam int IREF_TIMER_COUNT    = 5;

   // ****************************************************************
   // Error register fields
   // ****************************************************************
   localparam int IREF_ERR_NVM       = 7;
   localparam int IREF_ERR_QWRITE    = 6;
   localparam int IREF_ERR_QOVF      = 5;
   localparam int IREF_ERR_SHORT     = 4;
   localparam int IREF_ERR_EMPTY     = 3;
   localparam int IREF_ERR_COLL      = 2;
   localparam int IREF_ERR_PROTOCOL  = 1;
   localparam int IREF_ERR_INTEGRITY = 0;
   localparam int IREF_ERR_COUNT     = 8;

   // ****************************************************************
   // Control register fields
   // ****************************************************************
   localparam int IREF_CTL_POLARITY  = 0;
   localparam int IREF_CTL_COLL_INTG = 1;
   localparam int IREF_CTL_MULTI     = 2;
   localparam int IREF_CTL_DISTURB   = 3;
   localparam int IREF_CTL_W         = 4;

   // ****************************************************************
   // Reset values and frame limits
   // ****************************************************************
   localparam logic [7:0]  IREF_RST_ENABLE_TWO = 8'h00;
   localparam logic [3:0]  IREF_RST_CONTROL    = 4'h0;
   localparam logic [7:0]  IREF_RST_COLL_POS   = 8'h00;
   localparam logic [15:0] IREF_MIN_FRAME_BITS = 16'h0004;
   localparam logic [15:0] IREF_MIN_EMD_BITS   = 16'h0018;

endpackage : iref_pkg

`default_nettype wire

// ---- core/iref_top.sv ----
// Purpose : Second interrupt enable register and contactless error flags
// Assumes : All event inputs come from logic on clk_i, single-cycle pulses
// Notes   : Registers over classic Wishbone, one aligned word each
//
// The Wishbone slave port was left to the implementer.
`default_nettype none

module iref_top
   import iref_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Pending requests
   input  wire logic        card_detect_event_i,
   input  wire logic [4:0]  timer_event_i,
   input  wire logic        first_group_pending_i,
   // Command and state reporting
   input  wire logic        nvm_cmd_done_i,
   input  wire logic        nvm_cmd_fault_i,
   input  wire logic        cl_cmd_start_i,
   input  wire logic        receive_start_i,
   input  wire logic        wait_data_entry_i,
   input  wire logic        err_flags_stored_i,
   input  wire logic        crc_sending_i,
   input  wire logic        rx_side_state_i,
   input  wire logic        auth_active_i,
   // Queue side
   input  wire logic        queue_write_i,
   input  wire logic        queue_full_i,
   input  wire logic        queue_empty_i,
   input  wire logic        tx_required_i,
   // Receiver side
   input  wire logic        frame_end_i,
   input  wire logic        frame_sof_valid_i,
   input  wire logic [15:0] frame_bits_i,
   input  wire logic        collision_i,
   input  wire logic        collision_in_eof_i,
   input  wire logic [6:0]  collision_pos_i,
   input  wire logic        collision_pos_ok_i,
   input  wire logic        protocol_cause_i,
   input  wire logic        integrity_cause_i,
   input  wire logic        rx_byte_store_i,
   // Results
   output logic             queue_write_accept_o,
   output logic             rx_byte_commit_o,
   output logic             rx_halt_o,
   output logic             receive_done_event_o,
   output logic             error_event_o,
   output logic             combined_event_o,
   output logic             irq_pin_o,
   output logic             irq_pin_oe_o
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic                  ack;
      logic [31:0]           dat;
      logic [7:0]            enable_two;
      logic [IREF_CTL_W-1:0] control;
      logic [7:0]            coll_pos;
      logic                  accept;
      logic                  commit;
      logic                  halt;
      logic                  rx_done;
      logic                  err_evt;
      logic                  combined;
      logic                  pin;
      logic                  pin_oe;
   } iref_state_t;

   iref_state_t s_q;
   iref_state_t s_d;

   logic [IREF_ERR_COUNT-1:0] err_set;
   logic [IREF_ERR_COUNT-1:0] err_clr;
   logic [IREF_ERR_COUNT-1:0] err_flags;

   logic bus_req;
   logic bus_wr;
   logic rx_clear;
   logic coll_counted;
   logic short_frame;
   logic emd_short;
   logic combined_now;
   logic error_now;
   logic pin_active;
   logic pin_level;

   // ****************************************************************
   // Error flag storage
   // ****************************************************************
   // One sticky flag per error bit, set beats clear
   for (genvar g = 0; g < IREF_ERR_COUNT; g++) begin : g_flag
      iref_flag u_flag (
         .clk_i  (clk_i),
         .rst_i  (rst_i),
         .set_i  (err_set[g]),
         .clr_i  (err_clr[g]),
         .flag_o (err_flags[g])
      );
   end

   // ****************************************************************
   // Event qualification
   // ****************************************************************
   // Receive-phase clear: plain receive start or transceive wait entry
   assign rx_clear = receive_start_i | wait_data_entry_i;

   // End-of-frame collisions are ignored entirely
   assign coll_counted = collision_i & ~collision_in_eof_i;

   // Frame shorter than the minimum bit count after a valid start
   assign short_frame = frame_end_i & frame_sof_valid_i
                      & (frame_bits_i < IREF_MIN_FRAME_BITS);

   // With disturbance suppression, frames under three bytes also drop
   assign emd_short = s_q.control[IREF_CTL_DISTURB]
                    & (frame_bits_i < IREF_MIN_EMD_BITS);

   // Set conditions for each flag
   always_comb begin
      err_set = '0;
      err_set[IREF_ERR_NVM]    = nvm_cmd_done_i & nvm_cmd_fault_i;
      err_set[IREF_ERR_QWRITE] = queue_write_i
                               & (crc_sending_i | rx_side_state_i
                                  | auth_active_i);
      err_set[IREF_ERR_QOVF]   = queue_write_i & queue_full_i;
      err_set[IREF_ERR_SHORT]  = short_frame;
      err_set[IREF_ERR_EMPTY]  = tx_required_i & queue_empty_i;
      err_set[IREF_ERR_COLL]   = coll_counted;
      err_set[IREF_ERR_PROTOCOL] = protocol_cause_i;
      err_set[IREF_ERR_INTEGRITY] = integrity_cause_i
         | (coll_counted & s_q.control[IREF_CTL_COLL_INTG]);
   end

   // Clear conditions for each flag
   always_comb begin
      err_clr = '0;
      // A clean nvm command completion replaces the earlier result
      err_clr[IREF_ERR_NVM] = nvm_cmd_done_i & ~nvm_cmd_fault_i;
      if (s_q.control[IREF_CTL_MULTI]) begin
         err_clr[IREF_ERR_QWRITE] = err_flags_stored_i;
      end else begin
         err_clr[IREF_ERR_QWRITE] = cl_cmd_start_i;
      end
      err_clr[IREF_ERR_QOVF]      = cl_cmd_start_i;
      err_clr[IREF_ERR_EMPTY]     = cl_cmd_start_i;
      err_clr[IREF_ERR_SHORT]     = rx_clear;
      err_clr[IREF_ERR_COLL]      = rx_clear;
      err_clr[IREF_ERR_PROTOCOL]  = rx_clear;
      err_clr[IREF_ERR_INTEGRITY] = rx_clear;
   end

   // ****************************************************************
   // Interrupt combination
   // ****************************************************************
   // Error request is level, from the flags that count for it
   assign error_now = err_flags[IREF_ERR_QWRITE]
                    | err_flags[IREF_ERR_QOVF]
                    | err_flags[IREF_ERR_PROTOCOL]
                    | err_flags[IREF_ERR_EMPTY]
                    | err_flags[IREF_ERR_INTEGRITY];

   // Any enabled request lights the combined request
   assign combined_now = first_group_pending_i
      | (card_detect_event_i
         & s_q.enable_two[IREF_EN_CARD_DETECT])
      | (|(timer_event_i
           & s_q.enable_two[IREF_EN_TIMER_HI:IREF_EN_TIMER_LO]));

   // Pin is active only when gated through
   assign pin_active = combined_now
                     & s_q.enable_two[IREF_EN_PIN_GATE];

   // Active level low unless the polarity control inverts it
   assign pin_level = pin_active
                    ^ ~s_q.control[IREF_CTL_POLARITY];

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   // Ack drops after one cycle so each access gets exactly one ack
   assign bus_req = cyc_i & stb_i & ~s_q.ack;
   assign bus_wr  = bus_req & we_i & sel_i[0];

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      s_d = s_q;

      // Single-cycle answer to every access, mapped or not
      s_d.ack = bus_req;
      s_d.dat = '0;
      if (bus_req && !we_i) begin
         unique case (adr_i)
            IREF_ADDR_ENABLE_TWO: s_d.dat[7:0] = s_q.enable_two;
            IREF_ADDR_ERROR:      s_d.dat[7:0] = err_flags;
            IREF_ADDR_CONTROL:
               s_d.dat[IREF_CTL_W-1:0] = s_q.control;
            IREF_ADDR_COLL_POS:   s_d.dat[7:0] = s_q.coll_pos;
            default:              s_d.dat = '0;
         endcase
      end

      // Only the low byte lane carries register bits
      if (bus_wr) begin
         unique case (adr_i)
            IREF_ADDR_ENABLE_TWO: s_d.enable_two = dat_i[7:0];
            IREF_ADDR_CONTROL:
               s_d.control = dat_i[IREF_CTL_W-1:0];
            default: ;
         endcase
      end

      // Keep the first collision position until the next receive
      if (rx_clear) begin
         s_d.coll_pos = IREF_RST_COLL_POS;
      end else if (coll_counted && !err_flags[IREF_ERR_COLL]) begin
         s_d.coll_pos = {collision_pos_ok_i, collision_pos_i};
      end

      // Full queue or a standing overflow discards the write
      s_d.accept = queue_write_i & ~queue_full_i
                 & ~err_flags[IREF_ERR_QOVF];

      // Byte in flight is dropped on a protocol fault
      s_d.commit = rx_byte_store_i & ~protocol_cause_i
                 & ~err_flags[IREF_ERR_PROTOCOL];

      // Reception stops on protocol faults, never on integrity ones
      s_d.halt = protocol_cause_i;

      // Short frames give no receive-done, decoder keeps listening
      s_d.rx_done = frame_end_i & ~short_frame & ~emd_short;

      s_d.err_evt  = error_now;
      s_d.combined = combined_now;

      // Push-pull drives both levels; open-drain only pulls low
      if (s_q.enable_two[IREF_EN_PIN_DRIVE]) begin
         s_d.pin    = pin_level;
         s_d.pin_oe = 1'b1;
      end else begin
         s_d.pin    = 1'b0;
         s_d.pin_oe = ~pin_level;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   // All enables and controls come up cleared, pin released
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q            <= '0;
         s_q.enable_two <= IREF_RST_ENABLE_TWO;
         s_q.control    <= IREF_RST_CONTROL;
         s_q.coll_pos   <= IREF_RST_COLL_POS;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign dat_o                = s_q.dat;
   assign ack_o                = s_q.ack;
   assign queue_write_accept_o = s_q.accept;
   assign rx_byte_commit_o     = s_q.commit;
   assign rx_halt_o            = s_q.halt;
   assign receive_done_event_o = s_q.rx_done;
   assign error_event_o        = s_q.err_evt;
   assign combined_event_o     = s_q.combined;
   assign irq_pin_o            = s_q.pin;
   assign irq_pin_oe_o         = s_q.pin_oe;

endmodule : iref_top

`default_nettype wire

// ---- dv/iref_host.sv ----
// Purpose : Host side model that watches the interrupt pin
// Assumes : Pin has a pull-up resistor on the board
// Notes   : Resolves the wire level from driver output and enable
`default_nettype none

module iref_host (
   input  wire logic irq_pin_o,
   input  wire logic irq_pin_oe_o,
   output logic      pin_level_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released pin floats up, so open-drain can only pull low
   assign pin_level_o = irq_pin_oe_o ? irq_pin_o : 1'b1;
endmodule // iref_host

`default_nettype wire

// ---- dv/iref_top_assertions.sv ----
// Purpose : Port level checks of the enable and error flag block
// Assumes : One clock, synchronous active high reset
// Notes   : Bound to iref_top after the module
`default_nettype none

module iref_top_assertions (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        ack_o,
   input  wire logic        queue_write_i,
   input  wire logic        queue_full_i,
   input  wire logic        queue_write_accept_o,
   input  wire logic        rx_byte_store_i,
   input  wire logic        protocol_cause_i,
   input  wire logic        integrity_cause_i,
   input  wire logic        rx_byte_commit_o,
   input  wire logic        rx_halt_o,
   input  wire logic        frame_end_i,
   input  wire logic        frame_sof_valid_i,
   input  wire logic [15:0] frame_bits_i,
   input  wire logic        receive_done_event_o,
   input  wire logic        error_event_o,
   input  wire logic        irq_pin_oe_o
);
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack missing after request");
   a_ack_one_cycle: assert property (ack_o |=> !ack_o)
      else $error("ack held too long");
   a_full_write_dropped: assert property (
      queue_write_i && queue_full_i |=> !queue_write_accept_o)
      else $error("write into full queue accepted");
   a_accept_has_cause: assert property (
      queue_write_accept_o |-> $past(queue_write_i) && !$past(queue_full_i))
      else $error("accept without a legal write");
   a_fault_byte_lost: assert property (
      rx_byte_store_i && protocol_cause_i |=> !rx_byte_commit_o)
      else $error("byte stored on protocol fault");
   a_fault_halts_rx: assert property (
      protocol_cause_i |=> rx_halt_o)
      else $error("reception not halted");
   a_short_no_done: assert property (
      frame_end_i && frame_sof_valid_i && frame_bits_i < 16'h0004
      |=> !receive_done_event_o)
      else $error("done raised on short frame");
   a_error_raised: assert property (
      (queue_write_i && queue_full_i) || protocol_cause_i
      || integrity_cause_i |-> ##[1:2] error_event_o)
      else $error("error request missing");
   a_pin_idle_reset: assert property (
      $fell(rst_i) |-> !irq_pin_oe_o)
      else $error("pin driven after reset");
endmodule // iref_top_assertions

bind iref_top iref_top_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
   .queue_write_i(queue_write_i), .queue_full_i(queue_full_i),
   .queue_write_accept_o(queue_write_accept_o),
   .rx_byte_store_i(rx_byte_store_i), .protocol_cause_i(protocol_cause_i),
   .integrity_cause_i(integrity_cause_i),
   .rx_byte_commit_o(rx_byte_commit_o), .rx_halt_o(rx_halt_o),
   .frame_end_i(frame_end_i), .frame_sof_valid_i(frame_sof_valid_i),
   .frame_bits_i(frame_bits_i), .receive_done_event_o(receive_done_event_o),
   .error_event_o(error_event_o), .irq_pin_oe_o(irq_pin_oe_o));

`default_nettype wire

// ---- dv/iref_top_bench.sv ----
// Purpose : Self-checking bench for the enable and error flag block
// Assumes : Wishbone answer one cycle after the request is taken
// Notes   : Status inputs are driven as one-cycle pulses
`default_nettype none

module iref_top_bench import iref_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i, stb_i, we_i, ack_o, pin_level;
   logic [7:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o;
   logic card_detect_event_i, first_group_pending_i, nvm_cmd_done_i;
   logic [4:0] timer_event_i;
   logic nvm_cmd_fault_i, cl_cmd_start_i, receive_start_i, wait_data_entry_i;
   logic err_flags_stored_i, crc_sending_i, rx_side_state_i, auth_active_i;
   logic queue_write_i, queue_full_i, queue_empty_i, tx_required_i;
   logic frame_end_i, frame_sof_valid_i, collision_i, collision_in_eof_i;
   logic [15:0] frame_bits_i;
   logic [6:0] collision_pos_i;
   logic collision_pos_ok_i, protocol_cause_i, integrity_cause_i;
   logic rx_byte_store_i, queue_write_accept_o, rx_byte_commit_o, rx_halt_o;
   logic receive_done_event_o, error_event_o, combined_event_o;
   logic irq_pin_o, irq_pin_oe_o;
   int err_count = 0;
   int check_count = 0;

   // ****************************************************************
   // Clock, design and host
   // ****************************************************************
   always #5 clk_i = ~clk_i;
   iref_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .card_detect_event_i(card_detect_event_i),
      .timer_event_i(timer_event_i), .first_group_pending_i(first_group_pending_i),
      .nvm_cmd_done_i(nvm_cmd_done_i), .nvm_cmd_fault_i(nvm_cmd_fault_i),
      .cl_cmd_start_i(cl_cmd_start_i), .receive_start_i(receive_start_i),
      .wait_data_entry_i(wait_data_entry_i),
      .err_flags_stored_i(err_flags_stored_i), .crc_sending_i(crc_sending_i),
      .rx_side_state_i(rx_side_state_i), .auth_active_i(auth_active_i),
      .queue_write_i(queue_write_i), .queue_full_i(queue_full_i),
      .queue_empty_i(queue_empty_i), .tx_required_i(tx_required_i),
      .frame_end_i(frame_end_i), .frame_sof_valid_i(frame_sof_valid_i),
      .frame_bits_i(frame_bits_i), .collision_i(collision_i),
      .collision_in_eof_i(collision_in_eof_i), .collision_pos_i(collision_pos_i),
      .collision_pos_ok_i(collision_pos_ok_i), .protocol_cause_i(protocol_cause_i),
      .integrity_cause_i(integrity_cause_i), .rx_byte_store_i(rx_byte_store_i),
      .queue_write_accept_o(queue_write_accept_o),
      .rx_byte_commit_o(rx_byte_commit_o), .rx_halt_o(rx_halt_o),
      .receive_done_event_o(receive_done_event_o),
      .error_event_o(error_event_o), .combined_event_o(combined_event_o),
      .irq_pin_o(irq_pin_o), .irq_pin_oe_o(irq_pin_oe_o));
   iref_host host_u (.irq_pin_o(irq_pin_o), .irq_pin_oe_o(irq_pin_oe_o),
      .pin_level_o(pin_level));

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic summarize;
      if (err_count == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // One classic cycle; waits for ack under a bound
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= wd;
      n = 0;
      do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1) begin err_count++; summarize(); end
      rd = dat_o;
      cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      wb(1'b1, a, d, x);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      wb(1'b0, a, 32'h0, x);
      chk(x, e);
   endtask
   // Drops every pulse and its qualifiers one edge after they rose
   task automatic clr;
      @(posedge clk_i);
      {nvm_cmd_done_i, nvm_cmd_fault_i, cl_cmd_start_i, receive_start_i} <= 4'h0;
      {wait_data_entry_i, err_flags_stored_i, crc_sending_i} <= 3'h0;
      {rx_side_state_i, auth_active_i, queue_write_i, queue_full_i} <= 4'h0;
      {queue_empty_i, tx_required_i, frame_end_i, frame_sof_valid_i} <= 4'h0;
      {collision_i, collision_in_eof_i, collision_pos_ok_i} <= 3'h0;
      {protocol_cause_i, integrity_cause_i, rx_byte_store_i} <= 3'h0;
   endtask
   // Registered outputs may lag two stages; look mid-cycle
   task automatic settle;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic s_regs;
      chk({error_event_o, pin_level}, 2'b01);
      rd_chk(IREF_ADDR_ENABLE_TWO, 32'h0);
      rd_chk(IREF_ADDR_ERROR, 32'h0);
      wr(IREF_ADDR_ENABLE_TWO, 32'hA5);
      rd_chk(IREF_ADDR_ENABLE_TWO, 32'hA5);
      wr(IREF_ADDR_ERROR, 32'hFF);
      rd_chk(IREF_ADDR_ERROR, 32'h0);
      rd_chk(8'h3C, 32'h0);
   endtask
   // Each source alone, then with only its own enable cleared
   task automatic s_irq;
      for (int i = 0; i < 6; i++) begin
         wr(IREF_ADDR_ENABLE_TWO, 32'h40 | (32'h1 << i));
         if (i == 5) card_detect_event_i <= 1'b1;
         else timer_event_i <= 5'h01 << i;
         settle(); chk({combined_event_o, pin_level}, 2'b10);
         wr(IREF_ADDR_ENABLE_TWO, 32'h7F ^ (32'h1 << i));
         settle(); chk({combined_event_o, pin_level}, 2'b01);
         @(posedge clk_i);
         card_detect_event_i <= 1'b0;
         timer_event_i <= 5'h00;
      end
      @(posedge clk_i) timer_event_i <= 5'h01;
      wr(IREF_ADDR_ENABLE_TWO, 32'h81);
      settle(); chk({irq_pin_oe_o, pin_level}, 2'b11);
      wr(IREF_ADDR_ENABLE_TWO, 32'hC1);
      settle(); chk({irq_pin_oe_o, pin_level}, 2'b10);
      wr(IREF_ADDR_CONTROL, 32'h1);
      settle(); chk({irq_pin_oe_o, pin_level}, 2'b11);
      wr(IREF_ADDR_CONTROL, 32'h0);
      wr(IREF_ADDR_ENABLE_TWO, 32'h41);
      settle(); chk({irq_pin_oe_o, pin_level}, 2'b10);
      timer_event_i <= 5'h00;
      first_group_pending_i <= 1'b1;
      wr(IREF_ADDR_ENABLE_TWO, 32'h40);
      settle(); chk(combined_event_o, 1'b1);
      @(posedge clk_i) first_group_pending_i <= 1'b0;
   endtask
   // Sets all eight flags one by one, then clears them by group
   task automatic s_err;
      logic [31:0] exp;
      exp = 32'h0;
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk_i);
         case (i)
            7: begin nvm_cmd_done_i <= 1'b1; nvm_cmd_fault_i <= 1'b1; end
            6: begin queue_write_i <= 1'b1; crc_sending_i <= 1'b1; end
            5: begin queue_write_i <= 1'b1; queue_full_i <= 1'b1; end
            4: begin frame_end_i <= 1'b1; frame_sof_valid_i <= 1'b1;
               frame_bits_i <= 16'h0003; end
            3: begin tx_required_i <= 1'b1; queue_empty_i <= 1'b1; end
            2: begin collision_i <= 1'b1; collision_pos_ok_i <= 1'b1;
               collision_pos_i <= 7'h05; end
            1: begin protocol_cause_i <= 1'b1; rx_byte_store_i <= 1'b1; end
            default: integrity_cause_i <= 1'b1;
         endcase
         clr();
         exp = exp | (32'h1 << i);
         rd_chk(IREF_ADDR_ERROR, exp);
      end
      rd_chk(IREF_ADDR_COLL_POS, 32'h85);
      @(posedge clk_i) queue_write_i <= 1'b1;
      @(posedge clk_i) queue_write_i <= 1'b0;
      @(negedge clk_i) chk(queue_write_accept_o, 1'b0);
      @(posedge clk_i) receive_start_i <= 1'b1;
      clr(); rd_chk(IREF_ADDR_ERROR, 32'hE8);
      @(posedge clk_i) cl_cmd_start_i <= 1'b1;
      clr(); rd_chk(IREF_ADDR_ERROR, 32'h80);
      @(posedge clk_i) nvm_cmd_done_i <= 1'b1;
      clr(); rd_chk(IREF_ADDR_ERROR, 32'h0);
      @(posedge clk_i) queue_write_i <= 1'b1;
      @(posedge clk_i) queue_write_i <= 1'b0;
      @(negedge clk_i) chk(queue_write_accept_o, 1'b1);
   endtask
   // Collision options, wait-for-data clear and multi-frame clear
   task automatic s_err2;
      wr(IREF_ADDR_CONTROL, 32'h6);
      collision_i <= 1'b1;
      collision_in_eof_i <= 1'b1;
      clr(); rd_chk(IREF_ADDR_ERROR, 32'h0);
      collision_i <= 1'b1;
      clr(); rd_chk(IREF_ADDR_ERROR, 32'h5);
      wait_data_entry_i <= 1'b1;
      clr(); rd_chk(IREF_ADDR_ERROR, 32'h0);
      queue_write_i <= 1'b1;
      rx_side_state_i <= 1'b1;
      clr(); rd_chk(IREF_ADDR_ERROR, 32'h40);
      err_flags_stored_i <= 1'b1;
      clr(); rd_chk(IREF_ADDR_ERROR, 32'h0);
      queue_write_i <= 1'b1;
      auth_active_i <= 1'b1;
      clr(); rd_chk(IREF_ADDR_ERROR, 32'h40);
   endtask
   // Suppressed short frame, then a long frame with a clean byte
   task automatic s_rx;
      wr(IREF_ADDR_CONTROL, 32'h8);
      {frame_end_i, frame_sof_valid_i} <= 2'h3;
      frame_bits_i <= 16'h0010;
      clr();
      @(negedge clk_i) chk(receive_done_event_o, 1'b0);
      @(posedge clk_i) frame_bits_i <= 16'h0020;
      {frame_end_i, rx_byte_store_i} <= 2'h3;
      clr();
      @(negedge clk_i) chk(receive_done_event_o, 1'b1);
      chk(rx_byte_commit_o, 1'b1);
      chk(error_event_o, 1'b1);
   endtask

   // Reset, then the scenarios in turn
   initial begin
      {cyc_i, stb_i, we_i, card_detect_event_i, first_group_pending_i} = 5'h0;
      {adr_i, sel_i, dat_i, timer_event_i, frame_bits_i} = 65'h0;
      collision_pos_i = 7'h00;
      sel_i = 4'hF;
      clr();
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      s_regs();
      s_irq();
      s_err();
      s_err2();
      s_rx();
      summarize();
   end
endmodule // iref_top_bench

`default_nettype wire
